// >>> sci_master.sv
// Two-wire bus master segment engine with its Wishbone register file.
// Assumes external pull-ups, a 50 MHz mclk and a same-clock pin mode.
//
// Chosen here: the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "sci_defs.svh"

module sci_master
	import sci_pkg::*;
(
	input  wire logic        mclk,          // System clock
	input  wire logic        rst,           // Synchronous reset
	input  wire logic        wb_cyc_i,      // Bus cycle
	input  wire logic        wb_stb_i,      // Strobe
	input  wire logic        wb_we_i,       // Write enable
	input  wire logic [17:0] wb_adr_i,      // Byte address
	input  wire logic [3:0]  wb_sel_i,      // Byte lanes
	input  wire logic [31:0] wb_dat_i,      // Write data
	output logic      [31:0] wb_dat_o,      // Read data
	output logic             wb_ack_o,      // Acknowledge
	input  wire logic [1:0]  pin_mode,      // Pin configuration
	input  wire logic        global_irq_en, // Global event mask
	output logic      [5:0]  irq_event,     // Masked event pulses
	input  wire logic        scl_i,         // Clock line level
	output logic             scl_o,         // Clock drive value
	output logic             scl_oe,        // Clock pulled low
	input  wire logic        sda_i,         // Data line level
	output logic             sda_o,         // Data drive value
	output logic             sda_oe         // Data pulled low
);

	sci_fn_t     func_sel;      // Controller function
	logic [3:0]  seg_req;       // Pending segment request
	logic        ack_select;    // Answer ACK on receive
	logic [3:0]  status;        // Finish and NACK flags
	logic [3:0]  lin_div;       // Linear divider
	logic [3:0]  exp_div;       // Exponent divider
	logic [5:0]  irq_mask;      // Controller event mask
	logic [7:0]  tx_byte;       // Transmit buffer
	logic        tx_valid;      // Transmit buffer full
	logic [7:0]  rx_byte;       // Receive buffer
	logic        rx_valid;      // Receive buffer full
	logic [1:0]  sync_a;        // First synchroniser stage
	logic [1:0]  sync_b;        // Second stage
	logic [1:0]  sync_c;        // Third stage
	logic [1:0]  line;          // Filtered {scl, sda}
	logic [6:0]  ref_acc;       // Reference rate accumulator
	logic        ref_tick;      // One 24 MHz reference tick
	logic [19:0] half_cnt;      // Half-period counter
	logic [19:0] half_len;      // Half period in ref ticks
	logic        scl_wait;      // Slave holds clock low
	logic        half_done;     // End of a half period
	sci_state_t  state;         // Engine state
	logic [1:0]  phase;         // Step within a segment
	logic [3:0]  bitn;          // Bit number 0..8
	logic [7:0]  shifter;       // Byte shifter
	logic        is_send;       // Bit segment transmits
	logic [5:0]  event_raw;     // Unmasked event pulses
	logic        enabled;       // Mode selects the bus master
	logic        bus_hit;       // Request at a register edge
	logic        wr_en;         // Write takes effect
	logic        rd_en;         // Read takes effect
	logic [15:0] reg_idx;       // Register index
	logic [15:0] wdata;         // Write data of lane 0 and 1
	logic        accept;        // Engine takes a request
	logic        legal_req;     // Written request is legal
	logic        sample;        // Data line at clock high
	logic [3:0]  bit_next;      // Next bit number
	logic [15:0] rd_mux;        // Selected read value

	assign enabled  = (func_sel == SCI_FN_I2C);
	assign bus_hit  = wb_cyc_i & wb_stb_i & wb_ack_o;
	assign wr_en    = bus_hit & wb_we_i;
	assign rd_en    = bus_hit & ~wb_we_i;
	assign reg_idx  = wb_adr_i[17:2];
	assign wdata    = wb_dat_i[15:0];
	assign sample   = line[0];
	assign bit_next = bitn + 4'h1;

	// Single request, two-wire pins only, engine free
	assign legal_req = enabled & (pin_mode == SCI_PIN_TWO_WIRE)
		& (state == SCI_IDLE) & (seg_req == 4'h0)
		& ((wdata[3:0] == 4'h1) | (wdata[3:0] == 4'h2)
		| (wdata[3:0] == 4'h4) | (wdata[3:0] == 4'h8));
	assign accept = enabled & (state == SCI_IDLE) & (seg_req != 4'h0);

	// Wishbone acknowledge, one cycle, registered read data
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end
		else
		begin
			wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
			wb_dat_o <= {16'h0000, rd_mux};
		end
	end

	// Read multiplexer; unmapped indexes read zero
	always_comb
	begin
		rd_mux = 16'h0000;
		case (reg_idx)
			`SCI_IDX_BYTE_PORT: rd_mux = {8'h00, rx_byte};
			`SCI_IDX_FUNC_SEL:  rd_mux = {14'h0000, func_sel};
			`SCI_IDX_SEG_CTRL:  rd_mux = {12'h000, seg_req};
			`SCI_IDX_ACK_CTRL:  rd_mux = {15'h0000, ack_select};
			`SCI_IDX_STATUS:    rd_mux = {12'h000, status};
			`SCI_IDX_LIN_DIV:   rd_mux = {12'h000, lin_div};
			`SCI_IDX_EXP_DIV:   rd_mux = {12'h000, exp_div};
			`SCI_IDX_IRQ_MASK:  rd_mux = {10'h000, irq_mask};
			default:            rd_mux = 16'h0000;
		endcase
	end

	// Configuration registers written from the bus
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			func_sel   <= SCI_FN_OFF;
			ack_select <= 1'b0;
			lin_div    <= `SCI_RST_DIV;
			exp_div    <= `SCI_RST_DIV;
			irq_mask   <= `SCI_RST_MASK;
		end
		else if (wr_en & wb_sel_i[0])
		begin
			case (reg_idx)
				`SCI_IDX_FUNC_SEL:  func_sel   <= sci_fn_t'(wdata[1:0]);
				`SCI_IDX_ACK_CTRL:  ack_select <= wdata[0];
				`SCI_IDX_LIN_DIV:   lin_div    <= wdata[3:0];
				`SCI_IDX_EXP_DIV:   exp_div    <= wdata[3:0];
				`SCI_IDX_IRQ_MASK:  irq_mask   <= wdata[5:0];
				default:            ;
			endcase
		end
	end

	// Segment request bits, cleared by the engine on completion
	always_ff @(posedge mclk)
	begin
		if (rst | ~enabled)
			seg_req <= 4'h0;
		else if (state != SCI_IDLE && half_done
			&& ((state == SCI_START && phase == 2'h3)
			|| (state == SCI_STOP && phase == 2'h2)
			|| (state == SCI_BITS && phase == 2'h1
			&& bitn == 4'h8)))
			seg_req <= 4'h0;
		else if (wr_en & wb_sel_i[0]
			& (reg_idx == `SCI_IDX_SEG_CTRL) & legal_req)
			seg_req <= wdata[3:0];
	end

	// One-byte transmit buffer
	always_ff @(posedge mclk)
	begin
		if (rst | ~enabled)
		begin
			tx_byte  <= `SCI_RST_BYTE;
			tx_valid <= 1'b0;
		end
		else if (wr_en & wb_sel_i[0] & (reg_idx == `SCI_IDX_BYTE_PORT))
		begin
			tx_byte  <= wdata[7:0];
			tx_valid <= 1'b1;
		end
		else if (accept & seg_req[`SCI_SEG_SEND])
			tx_valid <= 1'b0;                              // Byte consumed
	end

	// One-byte receive buffer; a full buffer keeps its old byte
	always_ff @(posedge mclk)
	begin
		if (rst | ~enabled)
		begin
			rx_byte  <= `SCI_RST_BYTE;
			rx_valid <= 1'b0;
		end
		else if (state == SCI_BITS && ~is_send && half_done
			&& phase == 2'h1 && bitn == 4'h7 && ~rx_valid)
		begin
			rx_byte  <= {shifter[6:0], sample};
			rx_valid <= 1'b1;
		end
		else if (rd_en & (reg_idx == `SCI_IDX_BYTE_PORT))
			rx_valid <= 1'b0;
	end

	// Three-stage line input, accepted when stages two and three agree
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			sync_a <= 2'h3;
			sync_b <= 2'h3;
			sync_c <= 2'h3;
			line   <= 2'h3;
		end
		else
		begin
			sync_a <= {scl_i, sda_i};
			sync_b <= sync_a;
			sync_c <= sync_b;
			for (int i = 0; i < 2; i++)
				if (sync_b[i] == sync_c[i])
					line[i] <= sync_c[i];
		end
	end

	// Reference tick at 24 MHz out of 50 MHz by a rate accumulator
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			ref_acc  <= 7'h00;
			ref_tick <= 1'b0;
		end
		else if (ref_acc + `SCI_REF_MHZ >= `SCI_CLK_MHZ)
		begin
			ref_acc  <= ref_acc + `SCI_REF_MHZ - `SCI_CLK_MHZ;
			ref_tick <= 1'b1;
		end
		else
		begin
			ref_acc  <= ref_acc + `SCI_REF_MHZ;
			ref_tick <= 1'b0;
		end
	end

	// Half period is (lin+1)*2^exp reference ticks, same for low and high
	assign half_len  = 20'({16'h0000, lin_div} + 20'h1) << exp_div;
	assign scl_wait  = ~scl_oe & ~line[1];                 // Stretching
	assign half_done = (state != SCI_IDLE) & ref_tick & ~scl_wait
		& (half_cnt == half_len - 20'h1);

	// Half-period counter, restarted with each segment
	always_ff @(posedge mclk)
	begin
		if (rst | accept | (state == SCI_IDLE))
			half_cnt <= 20'h00000;
		else if (ref_tick & ~scl_wait)
			half_cnt <= half_done ? 20'h00000 : half_cnt + 20'h1;
	end

	// Segment engine; no arbitration, drives as sole master
	always_ff @(posedge mclk)
	begin
		if (rst | ~enabled)
		begin
			state   <= SCI_IDLE;
			phase   <= 2'h0;
			bitn    <= 4'h0;
			shifter <= 8'h00;
			is_send <= 1'b0;
			scl_oe  <= 1'b0;
			sda_oe  <= 1'b0;
		end
		else
		begin
			case (state)
				SCI_IDLE:
				begin
					phase <= 2'h0;
					bitn  <= 4'h0;
					if (accept & seg_req[`SCI_SEG_START])
					begin
						state  <= SCI_START;
						scl_oe <= 1'b1;
						sda_oe <= 1'b0;
					end
					else if (accept & seg_req[`SCI_SEG_SEND])
					begin
						state   <= SCI_BITS;
						is_send <= 1'b1;
						shifter <= tx_byte;
						scl_oe  <= 1'b1;
						sda_oe  <= ~tx_byte[7];
					end
					else if (accept & seg_req[`SCI_SEG_RECV])
					begin
						state   <= SCI_BITS;
						is_send <= 1'b0;
						scl_oe  <= 1'b1;
						sda_oe  <= 1'b0;
					end
					else if (accept & seg_req[`SCI_SEG_STOP])
					begin
						state  <= SCI_STOP;
						scl_oe <= 1'b1;
						sda_oe <= 1'b1;
					end
				end
				SCI_START:
				if (half_done)
				begin
					// Release clock, drop data at clock high, then clock low
					phase <= phase + 2'h1;
					case (phase)
						2'h0:    scl_oe <= 1'b0;
						2'h1:    sda_oe <= 1'b1;
						2'h2:    scl_oe <= 1'b1;
						default: state  <= SCI_IDLE;
					endcase
				end
				SCI_BITS:
				if (half_done)
				begin
					if (phase == 2'h0)
					begin
						phase  <= 2'h1;
						scl_oe <= 1'b0;                    // High half
					end
					else
					begin
						phase   <= 2'h0;
						scl_oe  <= 1'b1;
						bitn    <= bit_next;
						shifter <= {shifter[6:0], sample};
						if (bitn == 4'h8)
						begin
							state  <= SCI_IDLE;
							sda_oe <= 1'b0;
						end
						else if (bit_next == 4'h8)
							sda_oe <= ~is_send & ack_select;
						else
							sda_oe <= is_send & ~shifter[6];
					end
				end
				SCI_STOP:
				if (half_done)
				begin
					// Release clock, then release data at clock high
					phase <= phase + 2'h1;
					case (phase)
						2'h0:    scl_oe <= 1'b0;
						2'h1:    sda_oe <= 1'b0;
						default: state  <= SCI_IDLE;
					endcase
				end
				default: state <= SCI_IDLE;
			endcase
		end
	end

	// Drive values are always low; lines are open drain
	always_ff @(posedge mclk)
	begin
		scl_o <= 1'b0;
		sda_o <= 1'b0;
	end

	// Raw event pulses of this cycle
	always_comb
	begin
		event_raw = 6'h00;
		if (half_done && state == SCI_START && phase == 2'h3)
			event_raw[`SCI_EV_CMD_FIN] = ~status[`SCI_ST_CMD_FIN];
		if (half_done && state == SCI_STOP && phase == 2'h2)
			event_raw[`SCI_EV_CMD_FIN] = ~status[`SCI_ST_CMD_FIN];
		if (half_done && state == SCI_BITS && phase == 2'h1
			&& bitn == 4'h8)
		begin
			event_raw[`SCI_EV_TX_FIN] = is_send & ~status[`SCI_ST_TX_FIN];
			event_raw[`SCI_EV_RX_FIN] = ~is_send & ~status[`SCI_ST_RX_FIN];
			event_raw[`SCI_EV_NACK]   = is_send & sample;
		end
		if (state == SCI_BITS && ~is_send && half_done
			&& phase == 2'h1 && bitn == 4'h7 && rx_valid)
			event_raw[`SCI_EV_OVERRUN] = 1'b1;
		if (accept & seg_req[`SCI_SEG_SEND] & ~tx_valid)
			event_raw[`SCI_EV_UNDERRUN] = 1'b1;
	end

	// Finish flags: cleared when a segment starts, set on completion; NACK flag set or cleared by each send
	always_ff @(posedge mclk)
	begin
		if (rst | ~enabled)
			status <= 4'h0;
		else if (accept)
			status[2:0] <= 3'h0;
		else
		begin
			if (event_raw[`SCI_EV_CMD_FIN])
				status[`SCI_ST_CMD_FIN] <= 1'b1;
			if (event_raw[`SCI_EV_TX_FIN])
				status[`SCI_ST_TX_FIN] <= 1'b1;
			if (event_raw[`SCI_EV_RX_FIN])
				status[`SCI_ST_RX_FIN] <= 1'b1;
			if (half_done && state == SCI_BITS && phase == 2'h1
				&& bitn == 4'h8 && is_send)
				status[`SCI_ST_NACK] <= sample;
		end
	end

	// Events leave only through both masks
	always_ff @(posedge mclk)
	begin
		if (rst)
			irq_event <= 6'h00;
		else
			irq_event <= event_raw & irq_mask & {6{global_irq_en}};
	end

endmodule : sci_master

// >>> sci_defs.svh
// Constants of the serial controller in two-wire master mode.
// Assumes inclusion by bare name from the top module and the test bench.
// Function
// - Mode field: 0 off, 1 UART, 2 SPI, 3 I2C
// - Master only, 100kbps and 400kbps supported
// - No arbitration, sole master on the bus
// - Lines only pulled low, otherwise released
// - Rate is 24MHz over 2(lin+1)2^exp
// - Linear and exponent settings range 0 to 15
// - One segment request at a time only
// - Receive answers ACK or NACK by select bit
// - One-byte transmit and receive buffers, software access
// - Start/stop bits self-clear, set command finished
// - Send clears on completion, sets transmit finished
// - Receive clears, sets receive finished, read byte
// - Flag records slave NACK or ACK
// - Data write pushes, data read pops
// - Events on finish flag rises and NACK
// - Overrun and underrun events raised
// - Events pass only when both masks enabled
`ifndef SCI_DEFS_SVH
`define SCI_DEFS_SVH

// Register indexes; byte address is four times the index
`define SCI_IDX_BYTE_PORT   16'h449E
`define SCI_IDX_FUNC_SEL    16'h44AA
`define SCI_IDX_SEG_CTRL    16'h4490
`define SCI_IDX_ACK_CTRL    16'h4492
`define SCI_IDX_STATUS      16'h4494
`define SCI_IDX_LIN_DIV     16'h4496
`define SCI_IDX_EXP_DIV     16'h4498
`define SCI_IDX_IRQ_MASK    16'h449A

// Segment control bit positions
`define SCI_SEG_START       0
`define SCI_SEG_SEND        1
`define SCI_SEG_RECV        2
`define SCI_SEG_STOP        3

// Status bit positions
`define SCI_ST_CMD_FIN      0
`define SCI_ST_TX_FIN       1
`define SCI_ST_RX_FIN       2
`define SCI_ST_NACK         3

// Event bit positions
`define SCI_EV_CMD_FIN      0
`define SCI_EV_TX_FIN       1
`define SCI_EV_RX_FIN       2
`define SCI_EV_NACK         3
`define SCI_EV_OVERRUN      4
`define SCI_EV_UNDERRUN     5

// Reset values
`define SCI_RST_BYTE        8'h00
`define SCI_RST_DIV         4'h0
`define SCI_RST_MASK        6'h00

// Reference clock and system clock in MHz
`define SCI_REF_MHZ         7'h18
`define SCI_CLK_MHZ         7'h32

`endif

// >>> sci_pkg.sv
// Types of the serial controller in two-wire master mode.
// Assumes the constants header sits in the same folder.
package sci_pkg;
	// Controller function select values
	typedef enum logic [1:0] {
		SCI_FN_OFF  = 2'h0,
		SCI_FN_UART = 2'h1,
		SCI_FN_SPI  = 2'h2,
		SCI_FN_I2C  = 2'h3
	} sci_fn_t;

	// Pin configuration supplied by the pin multiplexer
	typedef enum logic [1:0] {
		SCI_PIN_TWO_WIRE    = 2'h0,
		SCI_PIN_FOUR_MASTER = 2'h1,
		SCI_PIN_FOUR_ASYNC  = 2'h2,
		SCI_PIN_OTHER       = 2'h3
	} sci_pin_mode_t;

	// Segment engine states
	typedef enum logic [1:0] {
		SCI_IDLE  = 2'h0,
		SCI_START = 2'h1,
		SCI_BITS  = 2'h2,
		SCI_STOP  = 2'h3
	} sci_state_t;
endpackage : sci_pkg

// >>> sci_slave.sv
// Behavioural two-wire slave device facing the master under test.
// Assumes resolved line levels with pull-ups on both lines.
`timescale 1ns/1ps

module sci_slave
(
	input  wire logic       scl,     // Clock line level
	input  wire logic       sda,     // Data line level
	input  wire logic       nack,    // Refuse every byte taken
	input  wire logic [7:0] tx_byte, // Byte returned on reads
	output logic            sda_oe,  // Pull data line low
	output logic      [7:0] got,     // Last byte taken
	output logic            mack     // Master answer level seen
);
	int         bitn  = 10; // Bit index, 9 armed, 10 idle
	logic       rd    = 0;  // Read transfer in progress
	logic       first = 0;  // Address byte comes next
	logic [7:0] sh    = 0;  // Shift register
	initial sda_oe = 0;
	// Start or restart; wait out a same-step clock fall
	always @(negedge sda)
	begin
		#1;
		if (scl && !sda)
		begin
			bitn = 9;
			first = 1;
			rd = 0;
		end
	end
	// Stop frees the bus
	always @(posedge sda)
	begin
		#1;
		if (scl && sda)
			bitn = 10;
	end
	// Sample data while the clock is high
	always @(posedge scl)
	begin
		if (bitn < 8)
			sh = {sh[6:0], sda};
		if (bitn == 8)
			mack = sda;
		if (bitn == 8 && rd && !first && sda)
			bitn = 10; // Master refused, let go of the line
	end
	// Change the line drive only while the clock is low
	always @(negedge scl)
	begin
		if (bitn == 8)
		begin
			got = sh;
			if (first)
				rd = sh[0];
			first = 0;
		end
		if (bitn < 10)
			bitn = (bitn >= 8) ? 0 : bitn + 1;
		sda_oe = 0;
		if (bitn == 8 && (first || !rd))
			sda_oe = !nack;
		if (bitn < 8 && rd && !first)
			sda_oe = !tx_byte[7 - bitn];
	end
endmodule : sci_slave

// >>> sci_master_assertions.sv
// Port-level checker for the two-wire master register block.
// Assumes binding onto sci_master and one clock domain.
`timescale 1ns/1ps

module sci_master_assertions
(
	input wire logic        mclk,          // System clock
	input wire logic        rst,           // Synchronous reset
	input wire logic        wb_cyc_i,      // Bus cycle
	input wire logic        wb_stb_i,      // Strobe
	input wire logic        wb_we_i,       // Write enable
	input wire logic [31:0] wb_dat_o,      // Read data
	input wire logic        wb_ack_o,      // Acknowledge
	input wire logic        global_irq_en, // Global event mask
	input wire logic [5:0]  irq_event,     // Event pulses
	input wire logic        scl_o,         // Clock drive value
	input wire logic        scl_oe,        // Clock pulled low
	input wire logic        sda_o          // Data drive value
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	// Bus answers
	a_ack_after_req: assert property ($rose(wb_cyc_i && wb_stb_i) |=> wb_ack_o)
		else $error("ack missing after request");
	a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_ack_has_req: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without request");
	a_read_byte_wide: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h0)
		else $error("read data wider than a byte");
	// Lines
	a_drive_low_only: assert property (scl_o == 1'b0 && sda_o == 1'b0)
		else $error("line driven high");
	a_scl_low_min: assert property ($rose(scl_oe) |=> scl_oe)
		else $error("clock low phase too short");
	// Events
	a_irq_global: assert property (irq_event != 6'h00 |-> $past(global_irq_en))
		else $error("event passed global mask");
	a_irq_pulse: assert property (irq_event[2:0] != 3'h0 |=> irq_event[2:0] == 3'h0)
		else $error("finish event not a pulse");
	c_read: cover property (wb_ack_o && !wb_we_i);
	c_nack: cover property (irq_event[3]);
	c_overrun: cover property (irq_event[4]);
endmodule : sci_master_assertions

bind sci_master sci_master_assertions i_chk (.*);

// >>> sci_master_test.sv
// Self-checking bench for the two-wire master and its register file.
// Assumes the slave model and the checker are compiled before it.
`timescale 1ns/1ps
`include "sci_defs.svh"

module sci_master_test;
	import sci_pkg::*;
	localparam logic [15:0] BYT = `SCI_IDX_BYTE_PORT;
	localparam logic [15:0] FSEL = `SCI_IDX_FUNC_SEL;
	localparam logic [15:0] SEG = `SCI_IDX_SEG_CTRL;
	localparam logic [15:0] ACKC = `SCI_IDX_ACK_CTRL;
	localparam logic [15:0] STAT = `SCI_IDX_STATUS;
	localparam logic [15:0] LIN = `SCI_IDX_LIN_DIV;
	localparam logic [15:0] EXPD = `SCI_IDX_EXP_DIV;
	localparam logic [15:0] MSK = `SCI_IDX_IRQ_MASK;
	logic [15:0] regs [9] = '{BYT, FSEL, SEG, ACKC, STAT, LIN, EXPD, MSK,
		16'h0100}; // Last entry is unmapped
	logic        mclk = 0, rst = 1;             // Clock and reset
	logic        wb_cyc_i = 0, wb_stb_i = 0;    // Bus request
	logic        wb_we_i = 0;                   // Direction
	logic [17:0] wb_adr_i = 0;                  // Byte address
	logic [3:0]  wb_sel_i = 4'hF;               // Lanes
	logic [31:0] wb_dat_i = 0, wb_dat_o, rq;    // Data, taken read
	logic        wb_ack_o;                      // Answer
	logic [1:0]  pin_mode = 0;                  // Pin configuration
	logic        global_irq_en = 0, nack = 0;   // Mask, slave refusal
	logic [5:0]  irq_event;                     // Event pulses
	logic        scl_o, scl_oe, sda_o, sda_oe;  // Line drives
	logic        s_oe, mack, scl_d = 1;         // Slave, edge finder
	logic [7:0]  got, txb = 8'h00;              // Slave bytes
	int          n_fail = 0, n_checks = 0;      // Counters
	int          evc[6], snap[6], now, rise, per; // Monitors
	wire         scl_w = !scl_oe;               // Pulled-up clock
	wire         sda_w = !(sda_oe || s_oe);     // Pulled-up data

	sci_master i_dut (.*, .scl_i(scl_w), .sda_i(sda_w));
	sci_slave i_slv (.scl(scl_w), .sda(sda_w), .nack(nack),
		.tx_byte(txb), .sda_oe(s_oe), .got(got), .mack(mack));

	// Clock
	initial
	begin
		forever #10 mclk = ~mclk;
	end
	// Event counts and clock period
	always @(posedge mclk)
	begin
		now <= now + 1;
		scl_d <= scl_w;
		if (scl_w && !scl_d)
		begin
			per <= now - rise;
			rise <= now;
		end
		for (int i = 0; i < 6; i++)
			evc[i] <= evc[i] + irq_event[i];
	end

	task automatic chk(input string nm, input logic [31:0] e, g);
		n_checks++;
		if (g !== e)
		begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// One classic single cycle; waits for the answer
	task automatic xfer(input logic w, input logic [15:0] i,
		input logic [7:0] d);
		@(posedge mclk);
		wb_cyc_i <= 1;
		wb_stb_i <= 1;
		wb_we_i <= w;
		wb_adr_i <= {i, 2'h0};
		wb_dat_i <= {24'h0, d};
		do
			@(posedge mclk);
		while (wb_ack_o !== 1'b1); // Only the watchdog ends a hang
		chk("ack", 1, wb_ack_o);
		rq = wb_dat_o;
		wb_cyc_i <= 0;
		wb_stb_i <= 0;
	endtask : xfer

	task automatic rdchk(input string nm, input logic [15:0] i,
		input logic [31:0] e);
		xfer(0, i, 8'h00);
		chk(nm, e, rq);
	endtask : rdchk

	// Request a segment, poll its flag, check bit and events
	task automatic seg(input logic [3:0] b, input int fl,
		input logic [5:0] ex);
		int n;
		logic [5:0] sn;
		snap = evc;
		xfer(1, SEG, {4'h0, b});
		n = 0;
		do
		begin
			xfer(0, STAT, 8'h00);
			n++;
		end
		while (rq[fl] !== 1'b1 && n < 3000);
		rdchk("segment bits", SEG, 0);
		for (int i = 0; i < 6; i++)
			sn[i] = evc[i] != snap[i];
		chk("events", ex, sn);
	endtask : seg

	task automatic give_verdict;
		$display("checks %0d failures %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : give_verdict

	initial
	begin
		#2_000_000;
		n_fail++;
		give_verdict();
	end

	initial
	begin
		repeat (8) @(posedge mclk);
		rst <= 0;
		foreach (regs[i]) rdchk("reset value", regs[i], 0);
		$display("test reset done");
		for (int m = 0; m < 4; m++)
		begin
			xfer(1, FSEL, 8'h00);
			xfer(1, FSEL, 8'hFC | m);
			rdchk("mode", FSEL, m);
		end
		xfer(1, LIN, 8'hFF);
		rdchk("linear", LIN, 15);
		xfer(1, EXPD, 8'hF0);
		rdchk("exponent", EXPD, 0);
		xfer(1, LIN, 8'h01);
		pin_mode <= 1;
		xfer(1, SEG, 8'h01);
		rdchk("four-wire refusal", SEG, 0);
		pin_mode <= 0;
		xfer(1, SEG, 8'h03);
		rdchk("double refusal", SEG, 0);
		$display("test registers done");
		xfer(1, MSK, 8'h3F);
		global_irq_en <= 1;
		txb <= 8'hC3;
		seg(1, 0, 6'h01);
		xfer(1, BYT, 8'hA4);
		seg(2, 1, 6'h02);
		chk("slave byte", 8'hA4, got);
		rdchk("status", STAT, 2);
		xfer(1, BYT, 8'hF4);
		seg(2, 1, 6'h02);
		chk("slave byte", 8'hF4, got);
		xfer(1, BYT, 8'h5A);
		seg(2, 1, 6'h02);
		chk("slave byte", 8'h5A, got);
		seg(1, 0, 6'h01);
		xfer(1, BYT, 8'hA5);
		seg(2, 1, 6'h02);
		xfer(1, ACKC, 8'h01);
		seg(4, 2, 6'h04);
		chk("master ack", 0, mack);
		xfer(1, ACKC, 8'h00);
		seg(4, 2, 6'h14);
		chk("master nack", 1, mack);
		rdchk("rx byte", BYT, 8'hC3);
		seg(8, 0, 6'h01);
		$display("test frame done");
		nack <= 1;
		seg(1, 0, 6'h01);
		xfer(1, BYT, 8'hA4);
		seg(2, 1, 6'h0A);
		rdchk("nack status", STAT, 8'h0A);
		seg(2, 1, 6'h2A);
		seg(8, 0, 6'h01);
		nack <= 0;
		$display("test nack done");
		global_irq_en <= 0;
		seg(1, 0, 6'h00);
		global_irq_en <= 1;
		xfer(1, MSK, 8'h00);
		seg(8, 0, 6'h00);
		$display("test masks done");
		xfer(1, LIN, 8'h0E);
		xfer(1, EXPD, 8'h03);
		seg(1, 0, 6'h00);
		xfer(1, BYT, 8'h55);
		seg(2, 1, 6'h00);
		chk("scl period", (2 * 15 * 8 * 50) / 24,
			(per > 494 && per < 513) ? 500 : per);
		seg(8, 0, 6'h00);
		$display("test rate done");
		// Slower fast-mode setting keeps the low half near 1.3us
		xfer(1, LIN, 8'h0F);
		xfer(1, EXPD, 8'h01);
		seg(1, 0, 6'h00);
		xfer(1, BYT, 8'h3C);
		seg(2, 1, 6'h00);
		chk("scl period 375k", 1, (per >= 133 && per <= 142));
		seg(8, 0, 6'h00);
		$display("test compliant rate done");
		give_verdict();
	end
endmodule : sci_master_test
